//--- dht_defines.vh
`ifndef DHT_DEFINES_VH
`define DHT_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DHT_OFS_OUT_CTRL 8'h00
`define DHT_OFS_GLB_CTRL 8'h04
`define DHT_OFS_LO_COUNT 8'h08
`define DHT_OFS_UP_COUNT 8'h0c
`define DHT_OFS_LO_PERIOD 8'h10
`define DHT_OFS_UP_PERIOD 8'h14
`define DHT_OFS_PIN_CFG 8'h18

// ----------------------------------------------------------------
// output control fields
// ----------------------------------------------------------------
`define DHT_OC_LEVEL_BIT 0
`define DHT_OC_POL_BIT 1
`define DHT_OC_LO_ENA_LSB 6
`define DHT_OC_UP_ENA_LSB 22
`define DHT_OC_RESET 32'h0000_0000
`define DHT_OC_POL_RESET 1'b0

// ----------------------------------------------------------------
// global control fields
// ----------------------------------------------------------------
`define DHT_GC_LO_RUN_BIT 0
`define DHT_GC_UP_RUN_BIT 1
`define DHT_GC_TOPO_LSB 2
`define DHT_GC_LIMIT_LSB 8
`define DHT_GC_PCOUNT_LSB 12
`define DHT_GC_RESET 32'h0000_0000

// ----------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------
`define DHT_TOPO_64BIT 2'h0
`define DHT_TOPO_UNCHAINED 2'h1
`define DHT_TOPO_RESERVED 2'h2
`define DHT_TOPO_CHAINED 2'h3
`define DHT_ENA_OFF 2'h0
`define DHT_ENA_ONCE 2'h1
`define DHT_ENA_CONT 2'h2
`define DHT_ENA_RESERVED 2'h3
`define DHT_PERIOD_RESET 32'h0000_0000
`define DHT_PERIOD_FULL 32'hffff_ffff
`define DHT_RESP_OKAY 2'h0
`define DHT_RESP_SLVERR 2'h2

`endif

//--- dht_half_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "dht_defines.vh"

module dht_half_timer (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control
    input wire run,
    input wire step_en,
    input wire [1:0] enable_sel,
    input wire [3:0] presc_limit,
    input wire [31:0] period,
    // state
    output reg [3:0] presc_count,
    output reg [31:0] count,
    output reg match_pulse
);

// ----------------------------------------------------------------
// prescaler, counter and single-run stop
// ----------------------------------------------------------------
reg stopped_reg;
wire counting;

// reserved enable code behaves as disabled, holding the count
assign counting = ((enable_sel == `DHT_ENA_ONCE) || (enable_sel == `DHT_ENA_CONT))
                  && !stopped_reg && step_en;

// one process: prescale step, counter step and period handling
always @(posedge aclk) begin
    if (!aresetn) begin
        presc_count <= 4'h0;
        count <= 32'h0000_0000;
        stopped_reg <= 1'b0;
        match_pulse <= 1'b0;
    end else if (!run) begin
        presc_count <= 4'h0;
        count <= 32'h0000_0000;
        stopped_reg <= 1'b0;
        match_pulse <= 1'b0;
    end else begin
        match_pulse <= 1'b0;
        if (enable_sel == `DHT_ENA_OFF) begin
            stopped_reg <= 1'b0; // rearm a single run once disabled
        end
        if (counting) begin
            if (presc_count == presc_limit) begin
                presc_count <= 4'h0;
                if (count == period) begin
                    match_pulse <= 1'b1;
                    if (enable_sel == `DHT_ENA_ONCE) begin
                        stopped_reg <= 1'b1;
                    end else begin
                        count <= 32'h0000_0000;
                    end
                end else begin
                    count <= count + 32'h0000_0001;
                end
            end else begin
                presc_count <= presc_count + 4'h1;
            end
        end
    end
end

endmodule // dht_half_timer
`default_nettype wire

//--- dht_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// --------------------------------
// port checker
// --------------------------------
module dht_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // pin
    input wire logic timer_pin_out
);
    logic [7:0] ra;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // address of the read in flight, so data can be judged per register
    always @(posedge aclk) begin
        if (!aresetn)
            ra <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready)
            ra <= s_axi_araddr;
    end
    AST_RD_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    AST_ONE_RD: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted");
    AST_ONE_WR: assert property (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
        else $error("second write accepted");
    AST_OC_RSVD: assert property (
        s_axi_rvalid && ra == 8'h00 |-> (s_axi_rdata & 32'hff3f_ff3c) == 32'h0)
        else $error("output control spare bits set");
    AST_GC_RSVD: assert property (
        s_axi_rvalid && ra == 8'h04 |-> (s_axi_rdata & 32'hffff_00f0) == 32'h0)
        else $error("global control spare bits set");
    AST_HALT_ZERO: assert property (
        s_axi_rvalid && ra == 8'h04 && !s_axi_rdata[1] |-> s_axi_rdata[15:12] == 4'h0)
        else $error("prescale moves in reset");
    AST_UNMAPPED: assert property (s_axi_rvalid && ra >= 8'h1c |->
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("hole answered");
    AST_PIN_POL: assert property (
        $rose(s_axi_rvalid) && ra == 8'h00 |->
        timer_pin_out == (s_axi_rdata[0] ^ !s_axi_rdata[1]))
        else $error("pin polarity wrong");
    cover property ($rose(s_axi_rvalid) && ra == 8'h0c);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property ($rose(timer_pin_out));
endmodule // dht_monitor

bind dht_top dht_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .timer_pin_out(timer_pin_out));
`default_nettype wire

//--- dht_top.v
// What this block does
// - timer pin is the output inverted when polarity select is 0, straight when 1.
// - output level flag in control bit 0 is read-only and shows the timer output.
// - pin driven from the output level flag, through the polarity inversion.
// - flag reads 0 for a low timer output and 1 for a high one.
// - upper prescale count in global bits 15-12 advances every clock while enabled in unchained topology, once per lower match when chained or 64-bit.
// - after the prescale count meets the limit, counter steps and prescale returns to zero.
// - upper prescale limit held in global bits 11-8, set by software.
// - single-run upper half stops when its counter equals the period.
// - continuous upper half clears its counter after matching the period, then continues.
// - topology bits 3-2: 0 is 64-bit, 1 unchained, 3 chained, 2 reserved.
// - upper half held in reset while global bit 1 is 0, released when 1.
// - upper enable select, obeyed in unchained topology only: 0 hold, 1 run once, 2 continuous, 3 reserved.
// - lower half held in reset while its run bit is 0, released when 1.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "dht_defines.vh"

module dht_top (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // timer pin
    output reg timer_pin_out,
    output reg timer_pin_oe
);

// ----------------------------------------------------------------
// register state
// ----------------------------------------------------------------
reg output_polarity_select_reg;
reg [1:0] lower_enable_select_reg;
reg [1:0] upper_enable_select_reg;
reg [3:0] upper_prescale_limit_reg;
reg [1:0] counter_topology_select_reg;
reg upper_half_run_reg;
reg lower_half_run_reg;
reg [31:0] lower_period_reg;
reg [31:0] upper_period_reg;
reg pin_drive_reg;
reg output_level_flag_reg;

// write channel holding state
reg aw_held_reg;
reg w_held_reg;
reg [7:0] wr_addr_reg;
reg [31:0] wr_data_reg;
reg [3:0] wr_strb_reg;

// ----------------------------------------------------------------
// counter arrangement
// ----------------------------------------------------------------
wire [3:0] upper_prescale_count;
wire [31:0] upper_counter;
wire [31:0] lower_counter;
wire lower_match;
wire upper_match;
wire topo_64;
wire topo_unchained;
wire topo_chained;
reg upper_step;
reg [1:0] upper_ena_eff;
reg [31:0] lower_period_eff;

assign topo_64 = (counter_topology_select_reg == `DHT_TOPO_64BIT);
assign topo_unchained = (counter_topology_select_reg == `DHT_TOPO_UNCHAINED);
assign topo_chained = (counter_topology_select_reg == `DHT_TOPO_CHAINED);

// how each topology feeds the upper half; reserved topology stalls it
always @* begin
    upper_step = 1'b0;
    upper_ena_eff = `DHT_ENA_OFF;
    lower_period_eff = lower_period_reg;
    if (topo_unchained) begin
        upper_step = 1'b1;
        upper_ena_eff = upper_enable_select_reg;
    end else if (topo_chained) begin
        // lower half acts as prescaler stage for the upper
        upper_step = lower_match;
        upper_ena_eff = `DHT_ENA_CONT;
    end else if (topo_64) begin
        // lower period forced to all ones, so its match is the carry
        upper_step = lower_match;
        upper_ena_eff = lower_enable_select_reg;
        lower_period_eff = `DHT_PERIOD_FULL;
    end
end

dht_half_timer u_lower (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(lower_half_run_reg),
    .step_en(!(counter_topology_select_reg == `DHT_TOPO_RESERVED)),
    .enable_sel(lower_enable_select_reg),
    .presc_limit(4'h0),
    .period(lower_period_eff),
    .presc_count(),
    .count(lower_counter),
    .match_pulse(lower_match)
);

dht_half_timer u_upper (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(upper_half_run_reg),
    .step_en(upper_step),
    .enable_sel(upper_ena_eff),
    .presc_limit(upper_prescale_limit_reg),
    .period(upper_period_reg),
    .presc_count(upper_prescale_count),
    .count(upper_counter),
    .match_pulse(upper_match)
);

// ----------------------------------------------------------------
// timer output and pin
// ----------------------------------------------------------------
// output toggles on each upper period match, a plain 50% wave
always @(posedge aclk) begin
    if (!aresetn) begin
        output_level_flag_reg <= 1'b0;
    end else if (!upper_half_run_reg) begin
        output_level_flag_reg <= 1'b0;
    end else if (upper_match) begin
        output_level_flag_reg <= !output_level_flag_reg;
    end
end

// pin registered; lags the flag by one clock
always @(posedge aclk) begin
    if (!aresetn) begin
        timer_pin_out <= 1'b0;
        timer_pin_oe <= 1'b0;
    end else begin
        timer_pin_out <= output_polarity_select_reg ? output_level_flag_reg
                                                    : !output_level_flag_reg;
        timer_pin_oe <= pin_drive_reg;
    end
end

// ----------------------------------------------------------------
// byte strobe mask
// ----------------------------------------------------------------
wire [31:0] wr_mask;
wire [31:0] wr_lane;
genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
        assign wr_mask[gi*8 +: 8] = {8{wr_strb_reg[gi]}};
    end
endgenerate

// ----------------------------------------------------------------
// write channels
// ----------------------------------------------------------------
wire wr_fire;
wire [31:0] oc_cur;
wire [31:0] gc_cur;
wire [31:0] oc_new;
wire [31:0] gc_new;
wire [31:0] lp_new;
wire [31:0] up_new;
wire [31:0] pc_new;
wire wr_mapped;

assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
assign wr_lane = wr_data_reg & wr_mask;
assign oc_cur = {8'h00, upper_enable_select_reg, 14'h0000, lower_enable_select_reg,
                 4'h0, output_polarity_select_reg, 1'b0};
assign gc_cur = {20'h00000, upper_prescale_limit_reg, 4'h0, counter_topology_select_reg,
                 upper_half_run_reg, lower_half_run_reg};
assign oc_new = wr_lane | (oc_cur & ~wr_mask);
assign gc_new = wr_lane | (gc_cur & ~wr_mask);
assign lp_new = wr_lane | (lower_period_reg & ~wr_mask);
assign up_new = wr_lane | (upper_period_reg & ~wr_mask);
assign pc_new = wr_lane | ({31'h0, pin_drive_reg} & ~wr_mask);
assign wr_mapped = (wr_addr_reg <= `DHT_OFS_PIN_CFG); // map is contiguous and word aligned

// address and data are caught independently, in either order
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        wr_addr_reg <= 8'h00;
        wr_data_reg <= 32'h0000_0000;
        wr_strb_reg <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `DHT_RESP_OKAY;
    end else begin
        s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
        s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            wr_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wr_data_reg <= s_axi_wdata;
            wr_strb_reg <= s_axi_wstrb;
        end
        if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `DHT_RESP_OKAY : `DHT_RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            // release both holders only once the response is taken
            s_axi_bvalid <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

// register updates; counters are read-only, writes there are dropped
always @(posedge aclk) begin
    if (!aresetn) begin
        output_polarity_select_reg <= `DHT_OC_POL_RESET;
        lower_enable_select_reg <= `DHT_ENA_OFF;
        upper_enable_select_reg <= `DHT_ENA_OFF;
        upper_prescale_limit_reg <= 4'h0;
        counter_topology_select_reg <= `DHT_TOPO_64BIT;
        upper_half_run_reg <= 1'b0;
        lower_half_run_reg <= 1'b0;
        lower_period_reg <= `DHT_PERIOD_RESET;
        upper_period_reg <= `DHT_PERIOD_RESET;
        pin_drive_reg <= 1'b0;
    end else if (wr_fire) begin
        if (wr_addr_reg == `DHT_OFS_OUT_CTRL) begin
            output_polarity_select_reg <= oc_new[`DHT_OC_POL_BIT];
            lower_enable_select_reg <= oc_new[`DHT_OC_LO_ENA_LSB +: 2];
            upper_enable_select_reg <= oc_new[`DHT_OC_UP_ENA_LSB +: 2];
        end else if (wr_addr_reg == `DHT_OFS_GLB_CTRL) begin
            upper_prescale_limit_reg <= gc_new[`DHT_GC_LIMIT_LSB +: 4];
            counter_topology_select_reg <= gc_new[`DHT_GC_TOPO_LSB +: 2];
            upper_half_run_reg <= gc_new[`DHT_GC_UP_RUN_BIT];
            lower_half_run_reg <= gc_new[`DHT_GC_LO_RUN_BIT];
        end else if (wr_addr_reg == `DHT_OFS_LO_PERIOD) begin
            lower_period_reg <= lp_new;
        end else if (wr_addr_reg == `DHT_OFS_UP_PERIOD) begin
            upper_period_reg <= up_new;
        end else if (wr_addr_reg == `DHT_OFS_PIN_CFG) begin
            pin_drive_reg <= pc_new[0];
        end
    end
end

// ----------------------------------------------------------------
// read channel
// ----------------------------------------------------------------
reg [31:0] rd_word;
reg rd_ok;
wire [7:0] rd_addr;

assign rd_addr = {s_axi_araddr[7:2], 2'b00};

// read mux
always @* begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (rd_addr == `DHT_OFS_OUT_CTRL) begin
        rd_word = oc_cur | {31'h0, output_level_flag_reg};
    end else if (rd_addr == `DHT_OFS_GLB_CTRL) begin
        rd_word = gc_cur | {16'h0000, upper_prescale_count, 12'h000};
    end else if (rd_addr == `DHT_OFS_LO_COUNT) begin
        rd_word = lower_counter;
    end else if (rd_addr == `DHT_OFS_UP_COUNT) begin
        rd_word = upper_counter;
    end else if (rd_addr == `DHT_OFS_LO_PERIOD) begin
        rd_word = lower_period_reg;
    end else if (rd_addr == `DHT_OFS_UP_PERIOD) begin
        rd_word = upper_period_reg;
    end else if (rd_addr == `DHT_OFS_PIN_CFG) begin
        rd_word = {31'h0, pin_drive_reg};
    end else begin
        rd_ok = 1'b0;
    end
end

// one read at a time; data sampled at the address handshake
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `DHT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `DHT_RESP_OKAY : `DHT_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
    end
end

endmodule // dht_top
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, pin, oe;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    int err_count, checks_done, cyc;

    dht_top u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_pin_out(pin), .timer_pin_oe(oe));

    // --------------------------------
    // clock, cycle count, bus tasks
    // --------------------------------
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!awready);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!wready);
                wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wchk(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk(32'(r), 32'h0);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e);
        chk(32'(r), 32'h0);
    endtask

    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_polarity();
        rchk(8'h04, 32'h0);
        chk(32'(oe), 32'h0);
        wchk(8'h18, 32'h1);
        wchk(8'h00, 32'h0);
        repeat (2) @(posedge aclk);
        chk(32'(pin), 32'h1);
        chk(32'(oe), 32'h1);
        wchk(8'h00, 32'h2);
        repeat (2) @(posedge aclk);
        chk(32'(pin), 32'h0);
        rchk(8'h00, 32'h2);
        wchk(8'h00, 32'h3);
        rchk(8'h00, 32'h2);
        $display("polarity test done");
    endtask

    task automatic t_map();
        logic [31:0] d;
        logic [1:0] r;
        wchk(8'h00, 32'hff3f_ff3c);
        rchk(8'h00, 32'h0);
        wchk(8'h04, 32'hffff_00f0);
        rchk(8'h04, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wchk(8'h04, 32'(i) << 2);
            rchk(8'h04, 32'(i) << 2);
        end
        rd(8'h1c, d, r);
        chk(d, 32'h0);
        chk(32'(r), 32'h2);
        wr(8'h1c, 32'hffff_ffff, r);
        chk(32'(r), 32'h2);
        $display("map test done");
    endtask

    // one upper step per sixteen clocks with the widest prescale
    task automatic t_prescale();
        logic [31:0] c, g;
        logic [1:0] r;
        int t0, n, t;
        wchk(8'h14, 32'hffff_ffff);
        wchk(8'h04, 32'h0000_0f06);
        wchk(8'h00, 32'h0080_0000);
        t0 = cyc;
        repeat (160) @(posedge aclk);
        wchk(8'h00, 32'h0);
        n = cyc - t0;
        rd(8'h0c, c, r);
        rd(8'h04, g, r);
        t = int'(c) * 16 + int'(g[15:12]);
        chk(32'(t >= n - 2 && t <= n + 2), 32'h1);
        $display("prescale test done");
    endtask

    task automatic t_runs();
        logic [31:0] c, g;
        logic [1:0] r;
        wchk(8'h04, 32'h0);
        rchk(8'h0c, 32'h0);
        wchk(8'h14, 32'h3);
        wchk(8'h00, 32'h0040_0000);
        wchk(8'h04, 32'h0000_0206);
        repeat (60) @(posedge aclk);
        rchk(8'h0c, 32'h3);
        rchk(8'h00, 32'h0040_0001);
        chk(32'(pin), 32'h0);
        wchk(8'h00, 32'h0);
        wchk(8'h00, 32'h0080_0000);
        repeat (50) @(posedge aclk);
        rd(8'h00, g, r);
        chk(g & 32'hffff_fffe, 32'h0080_0000);
        wchk(8'h00, 32'h0);
        rd(8'h0c, c, r);
        chk(32'(c <= 32'h3), 32'h1);
        rd(8'h04, g, r);
        chk(32'(g[15:12] <= 4'h2), 32'h1);
        wchk(8'h04, 32'h4);
        rchk(8'h0c, 32'h0);
        wchk(8'h00, 32'h0080_0080);
        repeat (20) @(posedge aclk);
        rchk(8'h0c, 32'h0);
        rchk(8'h08, 32'h0);
        wchk(8'h10, 32'hff);
        wchk(8'h04, 32'h5);
        repeat (20) @(posedge aclk);
        rd(8'h08, c, r);
        chk(32'(c != 32'h0 && c <= 32'hff), 32'h1);
        wchk(8'h04, 32'h0);
        wchk(8'h10, 32'h4);
        wchk(8'h04, 32'h3);
        repeat (20) @(posedge aclk);
        rd(8'h08, c, r);
        chk(32'(c > 32'h4), 32'h1);
        rchk(8'h0c, 32'h0);
        wchk(8'h00, 32'h0);
        $display("run control test done");
    endtask

    // --------------------------------
    // sequence and verdict
    // --------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        tally_and_finish();
    end

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_polarity();
        t_map();
        t_prescale();
        t_runs();
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
